// ===== adc_link_pkg.sv
// constants shared by both ends of the converter readout link
// assumes a host clock of 20 MHz and a serial clock made by the host
package adc_link_pkg;

  // result format
  localparam int RESULT_W = 13;
  localparam int UNIPOLAR_BITS = 12;
  localparam logic [12:0] CODE_MOST_NEG = 13'h1000;
  localparam logic [12:0] CODE_MOST_POS = 13'h0fff;
  localparam logic [12:0] CODE_ZERO = 13'h0000;
  localparam logic [12:0] CODE_FIRST_POS = 13'h0001;

  // frame shape, counted in serial clock edges after select falls
  localparam int ACQ_HALF_CYCLES = 3;
  localparam int LOAD_FALL = ACQ_HALF_CYCLES / 2 + 1;
  localparam int CONV_CYCLES = RESULT_W;
  localparam int FIRST_DATA_RISE = LOAD_FALL + 1;
  localparam int TOTAL_RISES = LOAD_FALL + CONV_CYCLES;

  // host timing
  localparam int CLK_HZ = 20_000_000;
  localparam int MIN_SCLK_HZ = 85_000;
  localparam int DEFAULT_SCLK_HZ = 1_000_000;
  localparam int MAX_HALF_CYC = CLK_HZ / (2 * MIN_SCLK_HZ);
  localparam int MIN_HALF_CYC = 3;

  // result buffer
  localparam int FIFO_DEPTH = 8;

  // one-hot device frame states
  typedef enum logic [2:0] {
    DEV_ACQ = 3'h1,
    DEV_CONV = 3'h2,
    DEV_DONE = 3'h4
  } dev_state_t;

  // one-hot host sequencer states
  typedef enum logic [5:0] {
    HST_IDLE = 6'h01,
    HST_SETUP = 6'h02,
    HST_HIGH = 6'h04,
    HST_LOW = 6'h08,
    HST_GAP = 6'h10,
    HST_PUSH = 6'h20
  } host_state_t;

endpackage

// ===== adc_link_if.sv
// serial link between the converter end and the host end
// assumes a pull-up on the shared data line when nobody drives it
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk;
  logic select_powerdown_n;
  logic sdo_out;
  logic sdo_oe;
  wire sdo;

  // released line floats high through the pull-up
  assign sdo = sdo_oe ? sdo_out : 1'b1;

  modport device (
    input sclk,
    input select_powerdown_n,
    output sdo_out,
    output sdo_oe
  );

  modport host (
    output sclk,
    output select_powerdown_n,
    input sdo
  );
endinterface

// ===== adc_device_end.sv
// converter end of the serial readout link: acquisition, conversion, shift-out
// assumes the host makes the serial clock and holds it low while select is high
`timescale 1ns/1ps
module adc_device_end #(
  parameter int RES_W = adc_link_pkg::RESULT_W,
  parameter int IN_W = adc_link_pkg::RESULT_W + 1
) (
  // link
  adc_link_if.device link,
  // analog input stand-in, signed difference of the two inputs
  input wire logic signed [IN_W-1:0] diff_in,
  // status; results in the serial clock domain, standby straight from select
  output logic [RES_W-1:0] last_code,
  output logic last_negative,
  output logic last_clipped,
  output logic standby
);

  localparam logic [4:0] LOAD_FALL_C = 5'(adc_link_pkg::LOAD_FALL);
  localparam logic [4:0] LAST_SHIFT_C = 5'(adc_link_pkg::CONV_CYCLES - 1);
  localparam logic signed [IN_W-1:0] POS_LIMIT =
    IN_W'(signed'({1'b0, adc_link_pkg::CODE_MOST_POS}));
  localparam logic signed [IN_W-1:0] NEG_LIMIT =
    IN_W'(signed'({{(IN_W-RES_W){1'b1}}, adc_link_pkg::CODE_MOST_NEG}));

  // saturate the difference into the two's-complement code space
  function automatic logic [RES_W-1:0] to_code(input logic signed [IN_W-1:0] d);
    logic [RES_W-1:0] c;
    c = adc_link_pkg::CODE_ZERO;
    if (d > POS_LIMIT) begin
      c = adc_link_pkg::CODE_MOST_POS;
    end else if (d < NEG_LIMIT) begin
      c = adc_link_pkg::CODE_MOST_NEG;
    end else begin
      // zero maps to all-zero, one step up to the first positive code
      c = d[RES_W-1:0];
    end
    return c;
  endfunction

  function automatic logic is_clipped(input logic signed [IN_W-1:0] d);
    return (d > POS_LIMIT) || (d < NEG_LIMIT);
  endfunction

  adc_link_pkg::dev_state_t state_ff;
  logic [4:0] fall_cnt_ff;
  logic [4:0] shift_cnt_ff;
  logic [RES_W-1:0] shift_ff;
  logic signed [IN_W-1:0] diff_s1_ff;
  logic signed [IN_W-1:0] diff_s2_ff;
  logic load_now;
  logic last_shift;

  // the input is tracked on every serial clock rise through two stages; the load takes the value from the first rise
  always_ff @(posedge link.sclk) begin
    diff_s1_ff <= diff_in;
    diff_s2_ff <= diff_s1_ff;
  end

  // the hold point sits at the fall that ends 1.5 clocks of acquisition
  assign load_now = (state_ff == adc_link_pkg::DEV_ACQ) &&
                    (fall_cnt_ff == LOAD_FALL_C - 5'h01);
  assign last_shift = (state_ff == adc_link_pkg::DEV_CONV) &&
                      (shift_cnt_ff == LAST_SHIFT_C);

  // select high is the only reset this end has; the clock stands still then
  always_ff @(negedge link.sclk or posedge link.select_powerdown_n) begin
    if (link.select_powerdown_n) begin
      fall_cnt_ff <= 5'h00;
    end else if (fall_cnt_ff != 5'h1f) begin
      fall_cnt_ff <= fall_cnt_ff + 5'h01;
    end
  end

  // frame sequencing, one step per serial clock fall
  always_ff @(negedge link.sclk or posedge link.select_powerdown_n) begin
    if (link.select_powerdown_n) begin
      state_ff <= adc_link_pkg::DEV_ACQ;
    end else begin
      case (state_ff)
        adc_link_pkg::DEV_ACQ: begin
          if (load_now) begin
            state_ff <= adc_link_pkg::DEV_CONV;
          end
        end
        adc_link_pkg::DEV_CONV: begin
          if (last_shift) begin
            state_ff <= adc_link_pkg::DEV_DONE;
          end
        end
        adc_link_pkg::DEV_DONE: begin
          // one result per select low period; extra clocks leave the shifter holding zero on the line
          state_ff <= adc_link_pkg::DEV_DONE;
        end
        default: begin
          state_ff <= adc_link_pkg::DEV_ACQ;
        end
      endcase
    end
  end

  // bits converted so far
  always_ff @(negedge link.sclk or posedge link.select_powerdown_n) begin
    if (link.select_powerdown_n) begin
      shift_cnt_ff <= 5'h00;
    end else if (load_now) begin
      shift_cnt_ff <= 5'h00;
    end else if (state_ff == adc_link_pkg::DEV_CONV) begin
      shift_cnt_ff <= shift_cnt_ff + 5'h01;
    end
  end

  // output shifter, touched only on falling edges so the host has a stable rise
  always_ff @(negedge link.sclk or posedge link.select_powerdown_n) begin
    if (link.select_powerdown_n) begin
      shift_ff <= adc_link_pkg::CODE_ZERO;
    end else if (load_now) begin
      shift_ff <= to_code(diff_s2_ff);
    end else if (state_ff == adc_link_pkg::DEV_CONV) begin
      shift_ff <= {shift_ff[RES_W-2:0], 1'b0};
    end
  end

  // results kept for the user side; not cleared by select so they survive standby
  always_ff @(negedge link.sclk) begin
    if (load_now) begin
      last_code <= to_code(diff_s2_ff);
      last_negative <= diff_s2_ff < 0;
      last_clipped <= is_clipped(diff_s2_ff);
    end
  end

  // msb leads, so the sign is the first bit the host sees
  assign link.sdo_out = shift_ff[RES_W-1];
  // released while deselected so other converters can share the line
  assign link.sdo_oe = ~link.select_powerdown_n;
  assign standby = link.select_powerdown_n;

endmodule

// ===== adc_host_end.sv
// host end of the serial readout link with its result buffer
// assumes clk at 20 MHz and a synchronous active-low reset
//
// Functional notes
// - host pulls select low to start exchange
// - select high aborts conversion, enters standby
// - select returns high between every conversion
// - result output changes only on falling edges
// - host serial clock starts and paces conversion
// - acquisition lasts one and a half clocks
// - bipolar code spans all 8192 values
// - extremes are 0x1000 and 0x0fff
// - zero input gives zero, next is 0x0001
// - single polarity input keeps twelve-bit resolution
// - msb first, msb is the sign
// - host keeps serial clock at least 85 kHz
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = adc_link_pkg::RESULT_W,
  parameter int DEPTH = adc_link_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic do_wr;
  logic do_rd;

  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign in_ready = (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]) ||
                    (wr_ptr_ff[AW] == rd_ptr_ff[AW]);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
    end else if (do_wr) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr_ff <= '0;
    end else if (do_rd) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

endmodule

module adc_host_end #(
  parameter int SCLK_HZ = adc_link_pkg::DEFAULT_SCLK_HZ,
  parameter int DEPTH = adc_link_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  adc_link_if.host link,
  // control
  input wire logic run,
  output logic busy,
  // results
  output logic res_valid,
  input wire logic res_ready,
  output logic [adc_link_pkg::RESULT_W-1:0] res_data
);

  localparam int RW = adc_link_pkg::RESULT_W;
  localparam int HALF_RAW = adc_link_pkg::CLK_HZ / (2 * SCLK_HZ);
  // too slow a clock lets the held sample droop, too fast defeats the data sync
  localparam int HALF_CLAMP = (HALF_RAW > adc_link_pkg::MAX_HALF_CYC) ?
    adc_link_pkg::MAX_HALF_CYC : HALF_RAW;
  localparam int HALF_INT = (HALF_CLAMP < adc_link_pkg::MIN_HALF_CYC) ?
    adc_link_pkg::MIN_HALF_CYC : HALF_CLAMP;
  localparam logic [7:0] HALF_LAST = 8'(HALF_INT - 1);
  localparam logic [4:0] FIRST_DATA = 5'(adc_link_pkg::FIRST_DATA_RISE);
  localparam logic [4:0] TOTAL = 5'(adc_link_pkg::TOTAL_RISES);

  adc_link_pkg::host_state_t state_ff;
  adc_link_pkg::host_state_t nxt_state;
  logic [7:0] div_ff;
  logic [4:0] rise_cnt_ff;
  logic [RW-1:0] shift_ff;
  logic sclk_ff;
  logic sel_n_ff;
  logic sdo_s1_ff;
  logic sdo_s2_ff;
  logic half_done;
  logic push_ready;

  assign half_done = div_ff == HALF_LAST;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      adc_link_pkg::HST_IDLE: begin
        // a frame starts only when the buffer has room for its result
        if (run && push_ready) begin
          nxt_state = adc_link_pkg::HST_SETUP;
        end
      end
      adc_link_pkg::HST_SETUP: begin
        if (half_done) begin
          nxt_state = adc_link_pkg::HST_HIGH;
        end
      end
      adc_link_pkg::HST_HIGH: begin
        if (half_done) begin
          nxt_state = adc_link_pkg::HST_LOW;
        end
      end
      adc_link_pkg::HST_LOW: begin
        if (half_done) begin
          nxt_state = (rise_cnt_ff == TOTAL) ? adc_link_pkg::HST_GAP :
                      adc_link_pkg::HST_HIGH;
        end
      end
      adc_link_pkg::HST_GAP: begin
        if (half_done) begin
          nxt_state = adc_link_pkg::HST_PUSH;
        end
      end
      adc_link_pkg::HST_PUSH: begin
        if (push_ready) begin
          nxt_state = adc_link_pkg::HST_IDLE;
        end
      end
      default: begin
        nxt_state = adc_link_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= adc_link_pkg::HST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // half-period divider restarts with every state change
  always_ff @(posedge clk) begin
    if (!rst_n || nxt_state != state_ff) begin
      div_ff <= 8'h00;
    end else if (!half_done) begin
      div_ff <= div_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_ff == adc_link_pkg::HST_IDLE) begin
      rise_cnt_ff <= 5'h00;
    end else if (nxt_state == adc_link_pkg::HST_HIGH && state_ff != adc_link_pkg::HST_HIGH) begin
      rise_cnt_ff <= rise_cnt_ff + 5'h01;
    end
  end

  // serial clock idles low; select only low for one frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_ff <= 1'b0;
      sel_n_ff <= 1'b1;
    end else begin
      sclk_ff <= nxt_state == adc_link_pkg::HST_HIGH;
      sel_n_ff <= nxt_state == adc_link_pkg::HST_IDLE || nxt_state == adc_link_pkg::HST_GAP ||
                  nxt_state == adc_link_pkg::HST_PUSH;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdo_s1_ff <= 1'b1;
      sdo_s2_ff <= 1'b1;
    end else begin
      sdo_s1_ff <= link.sdo;
      sdo_s2_ff <= sdo_s1_ff;
    end
  end

  // sample late in the high half, long after the device's falling-edge update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_ff <= adc_link_pkg::CODE_ZERO;
    end else if (state_ff == adc_link_pkg::HST_HIGH && half_done &&
                 rise_cnt_ff >= FIRST_DATA) begin
      shift_ff <= {shift_ff[RW-2:0], sdo_s2_ff};
    end
  end

  assign link.sclk = sclk_ff;
  assign link.select_powerdown_n = sel_n_ff;
  assign busy = state_ff != adc_link_pkg::HST_IDLE;

  result_fifo #(
    .WIDTH(RW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(state_ff == adc_link_pkg::HST_PUSH),
    .in_ready(push_ready),
    .in_data(shift_ff),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

endmodule

// ===== adc_link_sva.sv
// checker on the serial link between the two ends
// assumes sclk is made from clk by the host end
`timescale 1ns/1ps
module adc_link_sva (
  // host clock domain
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic sclk,
  input wire logic select_powerdown_n,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sdo
);
  logic [4:0] rise_cnt_ff;
  logic [4:0] fall_cnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk) begin
    if (!rst_n || select_powerdown_n) rise_cnt_ff <= 5'h00;
    else if ($rose(sclk)) rise_cnt_ff <= rise_cnt_ff + 5'h01;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || select_powerdown_n) fall_cnt_ff <= 5'h00;
    else if ($fell(sclk)) fall_cnt_ff <= fall_cnt_ff + 5'h01;
  end
  sequence s_low_run;
    !select_powerdown_n && !$past(select_powerdown_n);
  endsequence
  sequence s_setup;
    !sclk [*2] ##[1:20] $rose(sclk);
  endsequence
  property p_oe;
    sdo_oe == !select_powerdown_n;
  endproperty
  property p_release;
    !sdo_oe |-> sdo;
  endproperty
  property p_idle_clk;
    select_powerdown_n && $past(select_powerdown_n) |-> !sclk;
  endproperty
  property p_fall_only;
    s_low_run ##0 $changed(sdo_out) |-> $fell(sclk);
  endproperty
  property p_load_time;
    s_low_run ##0 $changed(sdo_out) |-> fall_cnt_ff >= 5'h01;
  endproperty
  property p_first_rise;
    $fell(select_powerdown_n) |-> s_setup;
  endproperty
  property p_frame_len;
    $rose(select_powerdown_n) |-> rise_cnt_ff == 5'(adc_link_pkg::TOTAL_RISES);
  endproperty
  property p_no_extra;
    rise_cnt_ff <= 5'(adc_link_pkg::TOTAL_RISES);
  endproperty
  property p_gap;
    $rose(select_powerdown_n) |-> select_powerdown_n [*2];
  endproperty
  a_oe: assert property (p_oe) else $error("drive enable wrong");
  a_release: assert property (p_release) else $error("idle line low");
  a_idle_clk: assert property (p_idle_clk) else $error("sclk idle");
  a_fall_only: assert property (p_fall_only) else $error("data off fall");
  a_load_time: assert property (p_load_time) else $error("data early");
  a_first_rise: assert property (p_first_rise) else $error("no sclk");
  a_frame_len: assert property (p_frame_len) else $error("frame length");
  a_no_extra: assert property (p_no_extra) else $error("extra clocks");
  a_gap: assert property (p_gap) else $error("select gap short");
endmodule

// ===== adc_serial_readout_port_test.sv
// self-checking bench: host end facing device end, plus a bench-driven device end
// assumes the package, interface and both design ends are compiled first
`timescale 1ns/1ps
module adc_serial_readout_port_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic res_ready = 1'b0;
  logic signed [13:0] diff_in = 14'h0000;
  logic signed [13:0] diff2 = 14'h0000;
  logic busy, res_valid, standby, standby2, last_negative, last_clipped;
  logic [12:0] res_data, last_code, cap2;
  logic [12:0] wire_word = 13'h0000;
  logic [4:0] nrise = 5'h00;
  int n_fail = 0;
  int checks = 0;
  int frames = 0;
  int codes[8] = '{0, 1, -1, 4095, -4096, 5000, -5000, 2048};
  adc_link_if link ();
  adc_link_if link2 ();
  adc_device_end i_adc_device_end (.link(link), .diff_in(diff_in), .last_code(last_code),
    .last_negative(last_negative), .last_clipped(last_clipped), .standby(standby));
  adc_host_end #(.SCLK_HZ(3333333)) i_adc_host_end (.clk(clk), .rst_n(rst_n), .link(link),
    .run(run), .busy(busy), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data));
  adc_device_end i_adc_device_end_2 (.link(link2), .diff_in(diff2), .last_code(),
    .last_negative(), .last_clipped(), .standby(standby2));
  adc_link_sva i_adc_link_sva (.clk(clk), .rst_n(rst_n), .sclk(link.sclk),
    .select_powerdown_n(link.select_powerdown_n), .sdo_out(link.sdo_out),
    .sdo_oe(link.sdo_oe), .sdo(link.sdo));
  initial begin
    forever #25 clk = ~clk;
  end
  // bits taken on rises 3..15, as the host end should
  always @(posedge link.sclk or posedge link.select_powerdown_n) begin
    if (link.select_powerdown_n) nrise <= 5'h00;
    else begin
      nrise <= nrise + 5'h01;
      if (nrise >= 5'h02) wire_word <= {wire_word[11:0], link.sdo};
    end
  end
  always @(negedge link.select_powerdown_n) frames++;
  function automatic logic [12:0] code_of(input int d);
    if (d > 4095) return 13'h0fff;
    if (d < -4096) return 13'h1000;
    return 13'(d);
  endfunction
  task complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input string what, input logic [12:0] exp, input logic [12:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task timeout(input string what);
    n_fail++;
    $display("MISMATCH %s expected 1 seen 0", what);
    complete_run();
  endtask
  task t_convert(input int d);
    int i;
    @(posedge clk);
    diff_in <= 14'(d);
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    #1;
    check("busy", 13'h0001, {12'h000, busy});
    for (i = 0; i < 400 && res_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 400) timeout("res_valid");
    check("res_data", code_of(d), res_data);
    check("wire_word", code_of(d), wire_word);
    check("last_code", code_of(d), last_code);
    check("sign", {12'h000, d < 0}, {12'h000, last_negative});
    check("clipped", {12'h000, d > 4095 || d < -4096}, {12'h000, last_clipped});
    check("busy after push", 13'h0000, {12'h000, busy});
    check("standby idle", 13'h0001, {12'h000, standby});
    @(posedge clk);
    res_ready <= 1'b1;
    @(posedge clk);
    res_ready <= 1'b0;
  endtask
  // far side stalls until the buffer refuses, then drains it
  task t_fifo;
    int i;
    int f0;
    f0 = frames;
    @(posedge clk);
    diff_in <= 14'h0123;
    run <= 1'b1;
    for (i = 0; i < 2000 && frames - f0 < 8; i++) @(posedge clk);
    if (i == 2000) timeout("eight frames");
    repeat (300) @(posedge clk);
    check("frames when full", 13'h0008, 13'(frames - f0));
    run <= 1'b0;
    res_ready <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      check("fifo valid", 13'h0001, {12'h000, res_valid});
      check("fifo data", 13'h0123, res_data);
      @(posedge clk);
    end
    res_ready <= 1'b0;
    @(negedge clk);
    check("fifo empty", 13'h0000, {12'h000, res_valid});
  endtask
  task sclk2(input int n);
    repeat (n) begin
      #3 link2.sclk = 1'b1;
      cap2 = {cap2[11:0], link2.sdo};
      #3 link2.sclk = 1'b0;
    end
  endtask
  // select raised mid-frame, then a whole frame must start over
  task t_abort;
    @(posedge clk);
    diff2 <= -14'sd5;
    link2.select_powerdown_n <= 1'b0;
    sclk2(5);
    check("oe in frame", 13'h0001, {12'h000, link2.sdo_oe});
    @(posedge clk);
    link2.select_powerdown_n <= 1'b1;
    #1;
    check("standby", 13'h0001, {12'h000, standby2});
    check("oe released", 13'h0000, {12'h000, link2.sdo_oe});
    check("idle line", 13'h0001, {12'h000, link2.sdo});
    @(posedge clk);
    diff2 <= 14'h0555;
    link2.select_powerdown_n <= 1'b0;
    sclk2(15);
    check("restart code", 13'h0555, cap2);
    @(posedge clk);
    link2.select_powerdown_n <= 1'b1;
  endtask
  initial begin
    link2.sclk = 1'b0;
    link2.select_powerdown_n = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (codes[k]) t_convert(codes[k]);
    t_fifo();
    t_abort();
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule
